// file: design/fss_edge_sync.sv
// Two-stage synchroniser with edge detection for an asynchronous input
`timescale 1ns/1ps
module fss_edge_sync (
   // Clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // Asynchronous input
   input  wire logic async_in,
   // Synchronised level and edges
   output logic      level,
   output logic      rise,
   output logic      fall
);

   logic meta_q;
   logic sync_q;
   logic prev_q;

   // First stage feeds only the second stage
   always_ff @(posedge clk) begin
      if (rst) begin
         meta_q <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= sync_q;
      end
   end

   assign level = sync_q;
   assign rise  = sync_q & ~prev_q;
   assign fall  = ~sync_q & prev_q;

endmodule

// file: design/fss_pkg.sv
// Constants and types shared by the switching frequency sync block
package fss_pkg;

   // Clock and time base
   localparam int CLK_PERIOD_PS  = 5000;
   localparam int CLK_FREQ_KHZ   = 200000;
   localparam int FREE_FREQ_KHZ  = 300;
   localparam int FREE_PERIOD_CYC = CLK_FREQ_KHZ / FREE_FREQ_KHZ;

   // Reduced frequency fallback: 0.7 of free-running, so period scaled by 10/7
   localparam int TRANS_FREQ_NUM = 7;
   localparam int TRANS_FREQ_DEN = 10;
   localparam int TRANS_TIME_NS  = 20000;
   // Longest time, rounded down
   localparam int TRANS_CYC      = (TRANS_TIME_NS * 1000) / CLK_PERIOD_PS;

   // Loss timeout in eighths of the expected period (1.5 periods)
   localparam int LOSS_EIGHTHS   = 12;

   localparam int CNT_W          = 16;

   // Reset values
   localparam logic [CNT_W-1:0] CNT_RST = 16'h0000;

   // Role taken from the three-level selector pin
   typedef enum logic [2:0] {
      FSS_ROLE_MASTER    = 3'b001,
      FSS_ROLE_SLAVE_180 = 3'b010,
      FSS_ROLE_SLAVE_0   = 3'b100
   } fss_role_t;

   // Lock state of the cycle timer
   typedef enum logic [2:0] {
      FSS_LK_FREE   = 3'b001,
      FSS_LK_LOCKED = 3'b010,
      FSS_LK_TRANS  = 3'b100
   } fss_lock_t;

   // Status bundle seen by the rest of the controller
   typedef struct packed {
      fss_role_t role;
      fss_lock_t lock;
      logic      cycle_start;
   } fss_status_t;

endpackage

// file: design/fss_top.sv
// Switching cycle timer with master/slave frequency synchronisation
//
// Overview of operation
// - Selector at supply gives master, at ground slave-180, open gives slave-0.
// - Master drives sync line at own switching frequency, 50% duty.
// - Master sync falling edge coincides with high-side drive rising edge.
// - Slave-180 starts each high-side pulse on incoming rising edge.
// - Slave-0 starts each high-side pulse on incoming falling edge.
// - On clock loss in slave mode, switch at 0.7 times free-running frequency.
// - After about 20 us of reduced frequency, return to free-running frequency.
`timescale 1ns/1ps
module fss_top #(
   parameter int PERIOD_CYC = fss_pkg::FREE_PERIOD_CYC,
   parameter int TRANS_CYC  = fss_pkg::TRANS_CYC
) (
   // Clock and reset
   input  wire logic                     clk,
   input  wire logic                     rst,
   // Role selector pin, sensed as two levels
   input  wire logic                     role_at_supply,
   input  wire logic                     role_at_ground,
   // On-time of the high-side pulse, from the modulator
   input  wire logic [fss_pkg::CNT_W-1:0] on_time,
   // Synchronisation line, two-way
   input  wire logic                     sync_in,
   output logic                          sync_out,
   output logic                          sync_oe_n,
   // Gate drive
   output logic                          high_side_drive,
   // Status
   output fss_pkg::fss_status_t          status
);

   localparam int W = fss_pkg::CNT_W;
   // Reduced-frequency period, 1/0.7 of nominal
   localparam logic [W-1:0] FREE_LEN  = W'(PERIOD_CYC);
   localparam logic [W-1:0] TRANS_LEN =
      W'((PERIOD_CYC * fss_pkg::TRANS_FREQ_DEN) / fss_pkg::TRANS_FREQ_NUM);
   // Must exceed the slowest legal external period (1/0.7 of nominal)
   localparam logic [W-1:0] LOSS_LEN  = W'((PERIOD_CYC * fss_pkg::LOSS_EIGHTHS) / 8);
   localparam logic [W-1:0] TRANS_END = W'(TRANS_CYC - 1);

   // Synchronised selector levels and sync line
   logic sup_lvl;
   logic gnd_lvl;
   logic sync_lvl;
   logic sync_rise;
   logic sync_fall;

   fss_edge_sync u_sup (
      .clk      (clk),
      .rst      (rst),
      .async_in (role_at_supply),
      .level    (sup_lvl),
      .rise     (),
      .fall     ()
   );

   fss_edge_sync u_gnd (
      .clk      (clk),
      .rst      (rst),
      .async_in (role_at_ground),
      .level    (gnd_lvl),
      .rise     (),
      .fall     ()
   );

   fss_edge_sync u_sync (
      .clk      (clk),
      .rst      (rst),
      .async_in (sync_in),
      .level    (sync_lvl),
      .rise     (sync_rise),
      .fall     (sync_fall)
   );

   // Role decode
   fss_pkg::fss_role_t role_q;
   fss_pkg::fss_role_t role_d;

   always_comb begin
      if (sup_lvl) begin
         role_d = fss_pkg::FSS_ROLE_MASTER;
      end else if (gnd_lvl) begin
         role_d = fss_pkg::FSS_ROLE_SLAVE_180;
      end else begin
         role_d = fss_pkg::FSS_ROLE_SLAVE_0;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         role_q <= fss_pkg::FSS_ROLE_SLAVE_0;
      end else begin
         role_q <= role_d;
      end
   end

   // Qualifying external edge, selected by role
   logic ext_edge;

   always_comb begin
      case (role_q)
         fss_pkg::FSS_ROLE_SLAVE_180: ext_edge = sync_rise;
         fss_pkg::FSS_ROLE_SLAVE_0:   ext_edge = sync_fall;
         default:                     ext_edge = 1'b0;
      endcase
   end

   // Lock state and cycle counter
   fss_pkg::fss_lock_t lock_q;
   fss_pkg::fss_lock_t lock_d;
   logic [W-1:0]       cnt_q;
   logic [W-1:0]       cnt_d;
   logic [W-1:0]       trans_q;
   logic [W-1:0]       trans_d;
   logic               start_d;
   logic               start_q;
   logic [W-1:0]       len;

   always_comb begin
      lock_d  = lock_q;
      cnt_d   = cnt_q + 1'b1;
      trans_d = trans_q;
      start_d = 1'b0;
      len     = (lock_q == fss_pkg::FSS_LK_TRANS) ? TRANS_LEN : FREE_LEN;
      case (lock_q)
         fss_pkg::FSS_LK_FREE: begin
            if (ext_edge) begin
               lock_d  = fss_pkg::FSS_LK_LOCKED;
               cnt_d   = fss_pkg::CNT_RST;
               start_d = 1'b1;
            end else if (cnt_q >= len - 1'b1) begin
               cnt_d   = fss_pkg::CNT_RST;
               start_d = 1'b1;
            end
         end
         fss_pkg::FSS_LK_LOCKED: begin
            // Cycle restarts on the external edge, on a change to master, or at the loss timeout while locked
            if (ext_edge) begin
               cnt_d   = fss_pkg::CNT_RST;
               start_d = 1'b1;
            end else if (role_q == fss_pkg::FSS_ROLE_MASTER) begin
               lock_d  = fss_pkg::FSS_LK_FREE;
               cnt_d   = fss_pkg::CNT_RST;
               start_d = 1'b1;
            end else if (cnt_q >= LOSS_LEN - 1'b1) begin
               lock_d  = fss_pkg::FSS_LK_TRANS;
               trans_d = fss_pkg::CNT_RST;
               cnt_d   = fss_pkg::CNT_RST;
               start_d = 1'b1;
            end
         end
         fss_pkg::FSS_LK_TRANS: begin
            trans_d = trans_q + 1'b1;
            if (ext_edge) begin
               lock_d  = fss_pkg::FSS_LK_LOCKED;
               cnt_d   = fss_pkg::CNT_RST;
               start_d = 1'b1;
            end else if (role_q == fss_pkg::FSS_ROLE_MASTER) begin
               // Fallback is a slave feature; a new master runs free at once
               lock_d = fss_pkg::FSS_LK_FREE;
            end else begin
               if (trans_q >= TRANS_END) begin
                  lock_d = fss_pkg::FSS_LK_FREE;
               end
               if (cnt_q >= len - 1'b1) begin
                  cnt_d   = fss_pkg::CNT_RST;
                  start_d = 1'b1;
               end
            end
         end
         default: begin
            lock_d = fss_pkg::FSS_LK_FREE;
            cnt_d  = fss_pkg::CNT_RST;
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         lock_q <= fss_pkg::FSS_LK_FREE;
      end else begin
         lock_q <= lock_d;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cnt_q   <= fss_pkg::CNT_RST;
         start_q <= 1'b0;
      end else begin
         cnt_q   <= cnt_d;
         start_q <= start_d;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         trans_q <= fss_pkg::CNT_RST;
      end else begin
         trans_q <= trans_d;
      end
   end

   // Gate drive and master pulse train, both from the next count so the
   // high-side rise and the sync fall land on the same clock edge
   logic [W-1:0] half_len;
   logic         hs_q;
   logic         sync_q;

   assign half_len = FREE_LEN >> 1;

   always_ff @(posedge clk) begin
      if (rst) begin
         hs_q <= 1'b0;
      end else begin
         hs_q <= (cnt_d < on_time);
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         sync_q <= 1'b0;
      end else begin
         // High in second half of the period, falls at cycle start
         sync_q <= (role_q == fss_pkg::FSS_ROLE_MASTER) && (cnt_d >= half_len);
      end
   end

   // Line is released in both slave modes
   assign sync_out        = sync_q;
   assign sync_oe_n       = (role_q != fss_pkg::FSS_ROLE_MASTER);
   assign high_side_drive = hs_q;

   assign status.role        = role_q;
   assign status.lock        = lock_q;
   assign status.cycle_start = start_q;

endmodule

// file: dv/fss_clk_src.sv
// External sync clock source model
`timescale 1ns/1ps
module fss_clk_src #(
   parameter real HALF_NS = 62.5
) (
   // Run control and clock
   input  wire logic en,
   output logic      sync_clk
);
   // Odd offset keeps edges apart from the system clock
   initial begin
      sync_clk = 1'b0;
      #1.3;
      forever begin
         #(HALF_NS);
         sync_clk = en ? ~sync_clk : 1'b0;
      end
   end
endmodule

// file: dv/fss_top_props.sv
// Port assertions for the switching frequency sync block
`timescale 1ns/1ps
module fss_top_props #(
   parameter int PERIOD_CYC = 32,
   parameter int TRANS_CYC  = 200
) (
   // Clock and reset
   input wire logic                 clk,
   input wire logic                 rst,
   // Role selector pins
   input wire logic                 role_at_supply,
   input wire logic                 role_at_ground,
   // Sync line and drive
   input wire logic                 sync_in,
   input wire logic                 sync_out,
   input wire logic                 sync_oe_n,
   input wire logic                 high_side_drive,
   input wire fss_pkg::fss_status_t status
);
   localparam int HALF = PERIOD_CYC / 2;
   localparam int TPER = PERIOD_CYC * 10 / 7;
   localparam int LOSS = PERIOD_CYC * 3 / 2;
   wire         mst = status.role == fss_pkg::FSS_ROLE_MASTER;
   wire         cs  = status.cycle_start;
   wire [2:0]   lk  = status.lock;
   logic [15:0] gap_q;
   logic [2:0]  prev_q;
   // Zero lock code marks no start seen yet
   always_ff @(posedge clk) begin
      if (rst) begin
         gap_q  <= 16'h0000;
         prev_q <= 3'h0;
      end else if (cs) begin
         gap_q  <= 16'h0001;
         prev_q <= lk;
      end else begin
         gap_q <= gap_q + 16'h0001;
      end
   end
   logic [15:0] tr_q;
   // Cycles spent in the fallback state
   always_ff @(posedge clk) begin
      if (rst || lk != fss_pkg::FSS_LK_TRANS) begin
         tr_q <= 16'h0000;
      end else begin
         tr_q <= tr_q + 16'h0001;
      end
   end
   function automatic fss_pkg::fss_role_t exp_role(input logic s, input logic g);
      return s ? fss_pkg::FSS_ROLE_MASTER : (g ? fss_pkg::FSS_ROLE_SLAVE_180 : fss_pkg::FSS_ROLE_SLAVE_0);
   endfunction
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_lost;
      lk == fss_pkg::FSS_LK_LOCKED ##1 lk == fss_pkg::FSS_LK_TRANS;
   endsequence
   sequence s_fallback_end;
      lk == fss_pkg::FSS_LK_TRANS ##1 lk == fss_pkg::FSS_LK_FREE;
   endsequence
   chk_oe_role: assert property (sync_oe_n == !mst)
      else $error("sync enable wrong");
   chk_master_edge: assert property (mst && $fell(sync_out) |-> $rose(high_side_drive))
      else $error("sync fall without drive");
   chk_master_duty: assert property (mst && $rose(sync_out) |-> ##HALF ($fell(sync_out) || !mst))
      else $error("sync high time wrong");
   chk_edge_rise: assert property (status.role == fss_pkg::FSS_ROLE_SLAVE_180 && $rose(sync_in) |-> ##[3:5] cs)
      else $error("no start on rise");
   chk_edge_fall: assert property (status.role == fss_pkg::FSS_ROLE_SLAVE_0 && $fell(sync_in) |-> ##[3:5] cs)
      else $error("no start on fall");
   chk_free_period: assert property (cs && lk == 3'h1 && prev_q == 3'h1 |-> gap_q == PERIOD_CYC)
      else $error("free period wrong");
   chk_trans_period: assert property (cs && lk == 3'h4 && prev_q == 3'h4 |-> gap_q == TPER)
      else $error("fallback period wrong");
   chk_loss_time: assert property (s_lost |-> gap_q >= LOSS - 1 && gap_q <= LOSS + 2)
      else $error("loss timing wrong");
   chk_fallback_len: assert property (s_fallback_end |-> tr_q == TRANS_CYC)
      else $error("fallback time wrong");
   chk_role_map: assert property (status.role == exp_role($past(role_at_supply, 3), $past(role_at_ground, 3)))
      else $error("role decode wrong");
endmodule
bind fss_top fss_top_props #(.PERIOD_CYC(PERIOD_CYC), .TRANS_CYC(TRANS_CYC)) props_u (
   .clk(clk), .rst(rst), .role_at_supply(role_at_supply), .role_at_ground(role_at_ground),
   .sync_in(sync_in), .sync_out(sync_out), .sync_oe_n(sync_oe_n),
   .high_side_drive(high_side_drive), .status(status));

// file: dv/tb.sv
// Self-checking bench for the sync block
`timescale 1ns/1ps
module tb;
   localparam int PER = 32;
   logic                      clk = 1'b0;
   logic                      rst = 1'b1;
   logic                      role_at_supply = 1'b0;
   logic                      role_at_ground = 1'b0;
   logic                      src_en = 1'b0;
   logic [fss_pkg::CNT_W-1:0] on_time = 16'h0006;
   logic                      src_clk;
   logic                      sync_out;
   logic                      sync_oe_n;
   logic                      high_side_drive;
   fss_pkg::fss_status_t      status;
   int                        err_count = 0;
   int                        checked = 0;
   int                        n;
   // Shared line: our driver wins while enabled
   wire sync_in = !sync_oe_n ? sync_out : src_clk;
   always #2.5 clk = ~clk;
   fss_top #(.PERIOD_CYC(PER), .TRANS_CYC(200)) dut_u (.clk(clk), .rst(rst), .role_at_supply(role_at_supply),
      .role_at_ground(role_at_ground), .on_time(on_time), .sync_in(sync_in), .sync_out(sync_out),
      .sync_oe_n(sync_oe_n), .high_side_drive(high_side_drive), .status(status));
   fss_clk_src src_u (.en(src_en), .sync_clk(src_clk));
   task automatic give_verdict;
      if (err_count == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic pins(input logic s, input logic g, input logic e, input int w);
      @(posedge clk);
      role_at_supply <= s;
      role_at_ground <= g;
      src_en         <= e;
      repeat (w) @(negedge clk);
   endtask
   // Cycles between two starts; ends on the second start
   task automatic gap(output int n);
      n = 0;
      while (status.cycle_start !== 1'b1 && n < 400) begin
         @(negedge clk);
         n++;
      end
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (status.cycle_start !== 1'b1 && n < 400);
   endtask
   task automatic wait_lock(input logic [2:0] exp, input int lim);
      int k;
      k = 0;
      while (status.lock !== exp && k < lim) begin
         @(negedge clk);
         k++;
      end
      cmp(16'(status.lock), 16'(exp));
   endtask
   task automatic t_master;
      int k;
      pins(1'b1, 1'b0, 1'b0, 8);
      cmp(16'(status.role), 16'(fss_pkg::FSS_ROLE_MASTER));
      cmp(16'(sync_oe_n), 16'h0000);
      gap(n);
      cmp(16'(n), 16'(PER));
      cmp(16'({high_side_drive, sync_out}), 16'h0002);
      k = 0;
      while (high_side_drive === 1'b1 && k < 400) begin
         @(negedge clk);
         k++;
      end
      cmp(16'(k), on_time);
   endtask
   task automatic t_slave(input logic g, input logic [2:0] role);
      // Role settles before the clock starts, so no edge meets a stale role
      pins(1'b0, g, 1'b0, 8);
      pins(1'b0, g, 1'b1, 120);
      cmp(16'(status.role), 16'(role));
      cmp(16'({status.lock, sync_oe_n}), 16'h0005);
      gap(n);
      cmp(16'(n), 16'h0019);
   endtask
   task automatic t_loss;
      pins(1'b0, 1'b1, 1'b0, 2);
      wait_lock(fss_pkg::FSS_LK_TRANS, 80);
      gap(n);
      cmp(16'(n), 16'(PER * 10 / 7));
      cmp(16'(status.lock), 16'(fss_pkg::FSS_LK_TRANS));
      wait_lock(fss_pkg::FSS_LK_FREE, 200);
      gap(n);
      cmp(16'(n), 16'(PER));
   endtask
   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(negedge clk);
      t_master();
      t_slave(1'b1, fss_pkg::FSS_ROLE_SLAVE_180);
      t_loss();
      t_slave(1'b0, fss_pkg::FSS_ROLE_SLAVE_0);
      give_verdict();
   end
   initial begin
      #50000;
      err_count++;
      give_verdict();
   end
endmodule
